/* File: cpm_map.svh */
// register offsets, flag positions, vectors and timing counts of the core register set
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH
// wishbone word indices (byte address = 4 * index)
`define CPM_IDX_SUM 3'h0
`define CPM_IDX_PTR 3'h1
`define CPM_IDX_STK 3'h2
`define CPM_IDX_FETCH 3'h3
`define CPM_IDX_FLAG 3'h4
`define CPM_IDX_STAT 3'h5
// reset value and stack low reload value
`define CPM_STK_RST 16'h00FF
`define CPM_STK_LOW_RELOAD 8'hFF
// flag byte bit positions
`define CPM_FB_V 7
`define CPM_FB_ONE6 6
`define CPM_FB_ONE5 5
`define CPM_FB_H 4
`define CPM_FB_I 3
`define CPM_FB_N 2
`define CPM_FB_Z 1
`define CPM_FB_C 0
// vectors, high byte at the lower address
`define CPM_VEC_RESET 16'hFFFE
`define CPM_VEC_TRAP 16'hFFFC
`define CPM_VEC_TRAP_MON 16'hFEFC
`define CPM_VEC_IRQ_TOP 16'hFFFA
// stack frame: byte indices for interrupt frame and single pushes
`define CPM_FRAME_LAST 3'h4
`define CPM_SINGLE_SUM 3'h5
`define CPM_SINGLE_UPPER 3'h6
// stop recovery in oscillator (clk_i) cycles
`define CPM_REC_SHORT 13'h0020
`define CPM_REC_LONG 13'h1000
`endif

/* File: cpm_pkg.sv */
// types shared by the core register set
package cpm_pkg;
	typedef enum logic [4:0]
	{
		OP_NOP, OP_LDA, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_ORA, OP_EOR,
		OP_ASL, OP_LSR, OP_BTST, OP_LDHX, OP_LDSP, OP_RSP, OP_EA_HX, OP_EA_SP,
		OP_FETCH, OP_JUMP, OP_BSGN, OP_CLI, OP_SEI, OP_PSHA, OP_PUSH_UPPER_BYTE, OP_PULA,
		OP_PULL_UPPER_BYTE, OP_RTI, OP_SWI, OP_WAIT, OP_STOP
	} cpm_op_t;

	// one micro command from the sequencer
	typedef struct packed
	{
		cpm_op_t op;
		logic [7:0] data;
		logic [15:0] addr;
		logic last;
	} cpm_cmd_t;

	typedef enum logic [2:0]
	{
		ST_RUN, ST_PUSH, ST_PULL, ST_VEC_HI, ST_VEC_LO, ST_WAIT, ST_STOP, ST_RECOVER
	} cpm_state_t;
endpackage

/* File: cpm_regs.sv */
// programmer-visible register set with stacking, vectors, low-power and break entry
// Function
// - eight-bit sum register holds operands and takes arithmetic and logic results
// - sixteen-bit pointer pair is upper byte over low byte, forms indexed addresses
// - any reset loads stack top with 0x00FF
// - stack low reload writes 0xFF to low byte, high byte kept
// - push decrements stack top, pull increments; stack offset modes use it as base
// - fetch counter steps per fetch; jumps, branches, interrupts load new address
// - reset loads fetch counter from vector at 0xFFFE high, 0xFFFF low
// - flag byte holds mask plus five flags; bits 6 and 5 read one
// - signed wrap flag follows two's complement overflow; signed branches test it
// - nibble carry flag follows carry from bit 3 to 4 on adds
// - mask set blocks interrupts; entry sets it after stacking, before vector
// - interrupt entry never stacks upper pointer byte; software pushes it
// - return from service pulls core registers including saved mask
// - reset sets mask; unmask op, wait, stop, flag pull or bus write clears it; highest priority first
// - result msb flag copies bit 7 of each result
// - empty result flag set for a zero result, cleared otherwise
// - borrow flag from add carry out, subtract borrow, bit test, shifts
// - wait clears mask, halts core clock; interrupt exit keeps it clear
// - stop clears mask, halts clock, restarts after stabilisation delay
// - break forces trap opcode, vector 0xFFFC or 0xFEFC in monitor mode
// - break starts after current instruction; match on last cycle starts at once
// - return from service in break ends break only if request is gone at its last pull
// - stop recovery is 32 cycles short or 4096 cycles long
`timescale 1ns/1ps
`include "cpm_map.svh"
module cpm_regs
	import cpm_pkg::*;
#(
	parameter logic [7:0] TRAP_OPCODE = 8'h00
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:2] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cmd_valid_i,
	input wire cpm_cmd_t cmd_i,
	output logic cmd_ready_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic [7:0] irq_req_i,
	input wire logic stop_wake_i,
	input wire logic short_rec_i,
	input wire logic brk_req_i,
	input wire logic monitor_i,
	output logic [7:0] sum_o,
	output logic [15:0] ptr_o,
	output logic [15:0] stk_o,
	output logic [15:0] fetch_o,
	output logic [7:0] flag_o,
	output logic [15:0] ea_o,
	output logic [7:0] ir_o,
	output logic ir_force_o,
	output logic core_clk_en_o,
	output logic brk_active_o
);
	cpm_state_t state_reg;
	logic [7:0] sum_reg;
	logic [7:0] upper_reg;
	logic [7:0] low_reg;
	logic [15:0] stk_reg;
	logic [15:0] fetch_reg;
	logic f_v, f_h, f_i, f_n, f_z, f_c;
	logic [2:0] idx_reg;
	logic [2:0] end_reg;
	logic [15:0] vec_reg;
	logic [12:0] rec_reg;
	logic bnd_reg;
	logic brk_pend_reg;
	logic [7:0] alu_res;
	logic [8:0] alu_sum;
	logic [4:0] alu_half;
	logic alu_c, alu_v, alu_h, cin, take, wb_wr;
	logic [7:0] flag_now;

	// lowest request index has highest priority
	function automatic logic [2:0] prio(input logic [7:0] req);
		logic [2:0] n;
		n = 3'h0;
		for (int k = 7; k >= 0; k--)
		begin
			if (req[k])
				n = 3'(k);
		end
		return n;
	endfunction

	// byte of the stack frame or single push at a given index
	function automatic logic [7:0] frame_byte(input logic [2:0] i, input logic [7:0] pl,
		input logic [7:0] ph, input logic [7:0] x, input logic [7:0] a,
		input logic [7:0] f, input logic [7:0] h);
		case (i)
			3'h0: return pl;
			3'h1: return ph;
			3'h2: return x;
			3'h3: return a;
			3'h4: return f;
			3'h5: return a; // single push of the sum register
			default: return h;
		endcase
	endfunction

	assign take = cmd_valid_i & cmd_ready_o;
	assign cin = f_c & ((cmd_i.op == OP_ADC) | (cmd_i.op == OP_SBC));
	// write lands at the edge where the master sees ack high
	assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	// constant ones in bits 6 and 5
	assign flag_now = {f_v, 1'b1, 1'b1, f_h, f_i, f_n, f_z, f_c};

	// result and flag outcome of the arithmetic and logic ops
	always_comb
	begin
		alu_sum = 9'h000;
		alu_half = 5'h00;
		alu_res = sum_reg;
		alu_c = f_c;
		alu_v = f_v;
		alu_h = f_h;
		case (cmd_i.op)
			OP_ADD, OP_ADC:
			begin
				alu_sum = {1'b0, sum_reg} + {1'b0, cmd_i.data} + {8'h00, cin};
				alu_half = {1'b0, sum_reg[3:0]} + {1'b0, cmd_i.data[3:0]} + {4'h0, cin};
				alu_res = alu_sum[7:0];
				alu_c = alu_sum[8];
				alu_h = alu_half[4];
				alu_v = (sum_reg[7] == cmd_i.data[7]) && (alu_sum[7] != sum_reg[7]);
			end
			OP_SUB, OP_SBC:
			begin
				alu_sum = {1'b0, sum_reg} - {1'b0, cmd_i.data} - {8'h00, cin};
				alu_res = alu_sum[7:0];
				alu_c = alu_sum[8];
				alu_v = (sum_reg[7] != cmd_i.data[7]) && (alu_sum[7] != sum_reg[7]);
			end
			OP_AND:
			begin
				alu_res = sum_reg & cmd_i.data;
				alu_v = 1'b0;
			end
			OP_ORA:
			begin
				alu_res = sum_reg | cmd_i.data;
				alu_v = 1'b0;
			end
			OP_EOR:
			begin
				alu_res = sum_reg ^ cmd_i.data;
				alu_v = 1'b0;
			end
			OP_LDA:
			begin
				alu_res = cmd_i.data;
				alu_v = 1'b0;
			end
			OP_ASL:
			begin
				alu_res = {sum_reg[6:0], 1'b0};
				alu_c = sum_reg[7];
				alu_v = sum_reg[7] ^ sum_reg[6];
			end
			OP_LSR:
			begin
				alu_res = {1'b0, sum_reg[7:1]};
				alu_c = sum_reg[0];
				alu_v = sum_reg[0];
			end
			OP_BTST: alu_c = cmd_i.data[cmd_i.addr[2:0]];
			default: ;
		endcase
	end

	// sequencer and programmer registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_VEC_HI;
			vec_reg <= `CPM_VEC_RESET;
			stk_reg <= `CPM_STK_RST;
			f_i <= 1'b1;
			f_v <= 1'b0;
			f_h <= 1'b0;
			f_n <= 1'b0;
			f_z <= 1'b0;
			f_c <= 1'b0;
			sum_reg <= 8'h00;
			upper_reg <= 8'h00;
			low_reg <= 8'h00;
			fetch_reg <= 16'h0000;
			ea_o <= 16'h0000;
			idx_reg <= 3'h0;
			end_reg <= 3'h0;
			rec_reg <= 13'h0000;
			bnd_reg <= 1'b0;
			brk_pend_reg <= 1'b0;
			brk_active_o <= 1'b0;
			ir_o <= 8'h00;
			ir_force_o <= 1'b0;
			core_clk_en_o <= 1'b1;
			cmd_ready_o <= 1'b0;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_wdata_o <= 8'h00;
		end
		else
		begin
			ir_force_o <= 1'b0;
			// a request held through its own routine must not re-enter it
			if (brk_req_i && !brk_active_o)
				brk_pend_reg <= 1'b1;
			unique case (state_reg)
				ST_RUN:
				begin
					if (bnd_reg)
					begin
						// instruction boundary: break first, then unmasked requests
						bnd_reg <= 1'b0;
						if (brk_pend_reg)
						begin
							brk_pend_reg <= 1'b0;
							brk_active_o <= 1'b1;
							ir_o <= TRAP_OPCODE;
							ir_force_o <= 1'b1;
							vec_reg <= monitor_i ? `CPM_VEC_TRAP_MON : `CPM_VEC_TRAP;
							idx_reg <= 3'h0;
							end_reg <= `CPM_FRAME_LAST;
							state_reg <= ST_PUSH;
						end
						else if (!f_i && (irq_req_i != 8'h00))
						begin
							vec_reg <= `CPM_VEC_IRQ_TOP - {12'h000, prio(irq_req_i), 1'b0};
							idx_reg <= 3'h0;
							end_reg <= `CPM_FRAME_LAST;
							state_reg <= ST_PUSH;
						end
						else
							cmd_ready_o <= 1'b1;
					end
					else if (take)
					begin
						if (cmd_i.last)
						begin
							bnd_reg <= 1'b1;
							cmd_ready_o <= 1'b0;
						end
						case (cmd_i.op)
							OP_LDA, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_ORA, OP_EOR,
							OP_ASL, OP_LSR:
							begin
								sum_reg <= alu_res;
								f_n <= alu_res[7];
								f_z <= (alu_res == 8'h00);
								f_c <= alu_c;
								f_v <= alu_v;
								f_h <= alu_h;
							end
							OP_BTST: f_c <= alu_c;
							OP_LDHX: {upper_reg, low_reg} <= cmd_i.addr;
							OP_LDSP: stk_reg <= cmd_i.addr;
							OP_RSP: stk_reg[7:0] <= `CPM_STK_LOW_RELOAD;
							OP_EA_HX: ea_o <= {upper_reg, low_reg} + cmd_i.addr;
							OP_EA_SP: ea_o <= stk_reg + cmd_i.addr;
							OP_FETCH: fetch_reg <= fetch_reg + 16'h0001;
							OP_JUMP: fetch_reg <= cmd_i.addr;
							OP_BSGN:
							begin
								// data bit 0 picks the taken sense of N xor V
								if ((f_n ^ f_v) == cmd_i.data[0])
									fetch_reg <= cmd_i.addr;
							end
							OP_CLI: f_i <= 1'b0;
							OP_SEI: f_i <= 1'b1;
							OP_PSHA, OP_PUSH_UPPER_BYTE:
							begin
								idx_reg <= (cmd_i.op == OP_PSHA) ? `CPM_SINGLE_SUM : `CPM_SINGLE_UPPER;
								end_reg <= (cmd_i.op == OP_PSHA) ? `CPM_SINGLE_SUM : `CPM_SINGLE_UPPER;
								cmd_ready_o <= 1'b0;
								state_reg <= ST_PUSH;
							end
							OP_PULA, OP_PULL_UPPER_BYTE:
							begin
								idx_reg <= (cmd_i.op == OP_PULA) ? `CPM_SINGLE_SUM : `CPM_SINGLE_UPPER;
								end_reg <= (cmd_i.op == OP_PULA) ? `CPM_SINGLE_SUM : `CPM_SINGLE_UPPER;
								cmd_ready_o <= 1'b0;
								state_reg <= ST_PULL;
							end
							OP_RTI:
							begin
								idx_reg <= `CPM_FRAME_LAST;
								end_reg <= 3'h0;
								cmd_ready_o <= 1'b0;
								state_reg <= ST_PULL;
							end
							OP_SWI:
							begin
								vec_reg <= `CPM_VEC_TRAP;
								idx_reg <= 3'h0;
								end_reg <= `CPM_FRAME_LAST;
								cmd_ready_o <= 1'b0;
								state_reg <= ST_PUSH;
							end
							OP_WAIT:
							begin
								f_i <= 1'b0;
								core_clk_en_o <= 1'b0;
								cmd_ready_o <= 1'b0;
								state_reg <= ST_WAIT;
							end
							OP_STOP:
							begin
								f_i <= 1'b0;
								core_clk_en_o <= 1'b0;
								cmd_ready_o <= 1'b0;
								state_reg <= ST_STOP;
							end
							default: ;
						endcase
					end
				end
				ST_PUSH:
				begin
					if (!mem_req_o)
					begin
						mem_req_o <= 1'b1;
						mem_we_o <= 1'b1;
						mem_addr_o <= stk_reg;
						mem_wdata_o <= frame_byte(idx_reg, fetch_reg[7:0], fetch_reg[15:8],
							low_reg, sum_reg, flag_now, upper_reg);
					end
					else if (mem_ack_i)
					begin
						mem_req_o <= 1'b0;
						stk_reg <= stk_reg - 16'h0001;
						idx_reg <= idx_reg + 3'h1;
						if (idx_reg == end_reg)
						begin
							if (end_reg == `CPM_FRAME_LAST)
							begin
								f_i <= 1'b1;
								state_reg <= ST_VEC_HI;
							end
							else
							begin
								bnd_reg <= 1'b1;
								state_reg <= ST_RUN;
							end
						end
					end
				end
				ST_PULL:
				begin
					if (!mem_req_o)
					begin
						mem_req_o <= 1'b1;
						mem_we_o <= 1'b0;
						mem_addr_o <= stk_reg + 16'h0001;
					end
					else if (mem_ack_i)
					begin
						mem_req_o <= 1'b0;
						stk_reg <= stk_reg + 16'h0001;
						idx_reg <= idx_reg - 3'h1;
						case (idx_reg)
							3'h0: fetch_reg[7:0] <= mem_rdata_i;
							3'h1: fetch_reg[15:8] <= mem_rdata_i;
							3'h2: low_reg <= mem_rdata_i;
							3'h3, `CPM_SINGLE_SUM: sum_reg <= mem_rdata_i;
							3'h4:
							begin
								// saved mask comes back with the flags
								{f_v, f_h, f_i, f_n, f_z, f_c} <= {mem_rdata_i[`CPM_FB_V],
									mem_rdata_i[`CPM_FB_H:`CPM_FB_C]};
							end
							default: upper_reg <= mem_rdata_i;
						endcase
						if (idx_reg == end_reg)
						begin
							if (end_reg == 3'h0 && brk_active_o && !brk_req_i)
								brk_active_o <= 1'b0;
							bnd_reg <= 1'b1;
							state_reg <= ST_RUN;
						end
					end
				end
				ST_VEC_HI, ST_VEC_LO:
				begin
					if (!mem_req_o)
					begin
						mem_req_o <= 1'b1;
						mem_we_o <= 1'b0;
						mem_addr_o <= (state_reg == ST_VEC_HI) ? vec_reg : vec_reg + 16'h0001;
					end
					else if (mem_ack_i)
					begin
						mem_req_o <= 1'b0;
						if (state_reg == ST_VEC_HI)
						begin
							fetch_reg[15:8] <= mem_rdata_i;
							state_reg <= ST_VEC_LO;
						end
						else
						begin
							fetch_reg[7:0] <= mem_rdata_i;
							cmd_ready_o <= 1'b1;
							state_reg <= ST_RUN;
						end
					end
				end
				ST_WAIT:
				begin
					// any request wakes; mask stays clear so it is taken next
					if (irq_req_i != 8'h00)
					begin
						core_clk_en_o <= 1'b1;
						bnd_reg <= 1'b1;
						state_reg <= ST_RUN;
					end
				end
				ST_STOP:
				begin
					if (stop_wake_i)
					begin
						rec_reg <= short_rec_i ? `CPM_REC_SHORT : `CPM_REC_LONG;
						state_reg <= ST_RECOVER;
					end
				end
				ST_RECOVER:
				begin
					rec_reg <= rec_reg - 13'h0001;
					if (rec_reg == 13'h0001)
					begin
						core_clk_en_o <= 1'b1;
						bnd_reg <= 1'b1;
						state_reg <= ST_RUN;
					end
				end
			endcase
			// software write from the bus wins over the core in the same cycle
			if (wb_wr && wb_sel_i[0])
			begin
				case (wb_adr_i)
					`CPM_IDX_SUM: sum_reg <= wb_dat_i[7:0];
					`CPM_IDX_PTR: low_reg <= wb_dat_i[7:0];
					`CPM_IDX_STK: stk_reg[7:0] <= wb_dat_i[7:0];
					`CPM_IDX_FETCH: fetch_reg[7:0] <= wb_dat_i[7:0];
					`CPM_IDX_FLAG:
					begin
						{f_v, f_h, f_i, f_n, f_z, f_c} <= {wb_dat_i[`CPM_FB_V],
							wb_dat_i[`CPM_FB_H:`CPM_FB_C]};
					end
					default: ;
				endcase
			end
			if (wb_wr && wb_sel_i[1])
			begin
				case (wb_adr_i)
					`CPM_IDX_PTR: upper_reg <= wb_dat_i[15:8];
					`CPM_IDX_STK: stk_reg[15:8] <= wb_dat_i[15:8];
					`CPM_IDX_FETCH: fetch_reg[15:8] <= wb_dat_i[15:8];
					default: ;
				endcase
			end
		end
	end

	// wishbone classic slave: one wait state, unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			case (wb_adr_i)
				`CPM_IDX_SUM: wb_dat_o <= {24'h000000, sum_reg};
				`CPM_IDX_PTR: wb_dat_o <= {16'h0000, upper_reg, low_reg};
				`CPM_IDX_STK: wb_dat_o <= {16'h0000, stk_reg};
				`CPM_IDX_FETCH: wb_dat_o <= {16'h0000, fetch_reg};
				`CPM_IDX_FLAG: wb_dat_o <= {24'h000000, flag_now};
				`CPM_IDX_STAT: wb_dat_o <= {26'h0000000, state_reg, brk_active_o,
					core_clk_en_o, cmd_ready_o};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// programmer view outputs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sum_o <= 8'h00;
			ptr_o <= 16'h0000;
			stk_o <= `CPM_STK_RST;
			fetch_o <= 16'h0000;
			flag_o <= 8'h68;
		end
		else
		begin
			sum_o <= sum_reg;
			ptr_o <= {upper_reg, low_reg};
			stk_o <= stk_reg;
			fetch_o <= fetch_reg;
			flag_o <= flag_now;
		end
	end
endmodule // cpm_regs

/* File: cpm_regs_properties.sv */
// assertion checker for the core register set ports
`timescale 1ns/1ps
module cpm_regs_checker
	import cpm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic cmd_valid_i,
	input wire cpm_cmd_t cmd_i,
	input wire logic cmd_ready_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic monitor_i,
	input wire logic [15:0] stk_o,
	input wire logic [7:0] flag_o,
	input wire logic ir_force_o,
	input wire logic core_clk_en_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic take;
	// command accepted this edge
	assign take = cmd_valid_i && cmd_ready_o;
	// flag byte and reset state
	AST_FLAG_ONES: assert property (flag_o[6:5] == 2'b11)
		else $error("flag byte fixed ones lost");
	AST_RST_STATE: assert property ($fell(rst_i) |-> stk_o == 16'h00FF && flag_o[3])
		else $error("reset state of stack top or mask wrong");
	AST_VEC_FETCH: assert property ($fell(rst_i) |-> ##[1:2]
		(mem_req_o && !mem_we_o && mem_addr_o == 16'hFFFE))
		else $error("reset vector not fetched");
	// bus handshakes
	AST_WB_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	AST_MEM_HOLD: assert property (mem_req_o && !mem_ack_i |=>
		mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
		else $error("memory request changed before ack");
	// instruction effects
	AST_RSP: assert property (take && cmd_i.op == OP_RSP |-> ##2
		(stk_o[7:0] == 8'hFF && stk_o[15:8] == $past(stk_o[15:8])))
		else $error("stack low reload wrong");
	AST_CLI: assert property (take && cmd_i.op == OP_CLI |-> ##2 !flag_o[3])
		else $error("unmask did not clear mask");
	AST_LOW_POWER: assert property (take && cmd_i.op inside {OP_WAIT, OP_STOP}
		|-> ##[2:4] (!core_clk_en_o && !flag_o[3]))
		else $error("low power entry wrong");
	AST_TRAP_VEC: assert property (ir_force_o |-> ##[1:60] (mem_req_o && !mem_we_o &&
		mem_addr_o == (monitor_i ? 16'hFEFC : 16'hFFFC)))
		else $error("break vector address wrong");
	// main scenarios
	COV_RTI: cover property (take && cmd_i.op == OP_RTI);
	COV_MON_BRK: cover property (ir_force_o && monitor_i);
	COV_WAKE: cover property ($rose(core_clk_en_o));
endmodule // cpm_regs_checker
bind cpm_regs cpm_regs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
	.cmd_ready_o(cmd_ready_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
	.mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .monitor_i(monitor_i), .stk_o(stk_o),
	.flag_o(flag_o), .ir_force_o(ir_force_o), .core_clk_en_o(core_clk_en_o));

/* File: cpm_mem_model.sv */
// memory partner answering the core's byte requests
`timescale 1ns/1ps
module cpm_mem_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic slow_i,
	output logic ack_o,
	output logic [7:0] rdata_o
);
	logic [7:0] store [0:65535];
	logic [1:0] cnt;
	// vectors: reset, two requests, break and monitor break
	initial
	begin
		foreach (store[i]) store[i] = 8'h00;
		store[16'hFFFE] = 8'h12;
		store[16'hFFFF] = 8'h34;
		store[16'hFFFA] = 8'h20;
		store[16'hFFF8] = 8'h21;
		store[16'hFFFC] = 8'h30;
		store[16'hFEFC] = 8'h40;
	end
	// answer after one or four cycles; idle data bus toggles
	always @(posedge clk_i)
	begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (rst_i)
		begin
			cnt <= 2'h0;
			rdata_o <= 8'h5A;
		end
		else if (req_i && !ack_o)
		begin
			if (cnt == (slow_i ? 2'h3 : 2'h0))
			begin
				cnt <= 2'h0;
				ack_o <= 1'b1;
				rdata_o <= store[addr_i];
				if (we_i) store[addr_i] <= wdata_i;
			end
			else cnt <= cnt + 2'h1;
		end
	end
endmodule // cpm_mem_model

/* File: cpm_regs_bench.sv */
// self-checking bench for the core register set
`timescale 1ns/1ps
module cpm_regs_bench;
	import cpm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cv = 1'b0;
	logic [2:0] adr = 3'h0;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	cpm_cmd_t cmd = '0;
	logic [7:0] irq = 8'h00;
	logic wake = 1'b0, srec = 1'b0, brk = 1'b0, mon = 1'b0, slow = 1'b0;
	logic ack, rdy, mreq, mwe, mack, force_ir, clk_en, brk_act;
	logic [15:0] maddr, ptr, stk, fch, ea;
	logic [7:0] mwd, mrd, sum, flg, ir;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	// trap opcode value is arbitrary, apart from the reset value of the opcode output
	cpm_regs #(.TRAP_OPCODE(8'h5C)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.cmd_valid_i(cv), .cmd_i(cmd), .cmd_ready_o(rdy), .mem_req_o(mreq), .mem_we_o(mwe),
		.mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_ack_i(mack), .mem_rdata_i(mrd),
		.irq_req_i(irq), .stop_wake_i(wake), .short_rec_i(srec), .brk_req_i(brk),
		.monitor_i(mon), .sum_o(sum), .ptr_o(ptr), .stk_o(stk), .fetch_o(fch), .flag_o(flg),
		.ea_o(ea), .ir_o(ir), .ir_force_o(force_ir), .core_clk_en_o(clk_en),
		.brk_active_o(brk_act));
	cpm_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .we_i(mwe),
		.addr_i(maddr), .wdata_i(mwd), .slow_i(slow), .ack_o(mack), .rdata_o(mrd));
	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;
	// hang guard
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			complete_run;
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// classic single bus cycle, held until ack
	task automatic wb(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [31:0] exp, input string what);
		wb(1'b0, a, 32'h0);
		chk(what, exp, rdat);
	endtask
	task automatic op(input cpm_op_t o, input logic [7:0] d, input logic [15:0] a);
		@(posedge clk_i);
		while (rdy !== 1'b1) @(posedge clk_i);
		cv <= 1'b1;
		cmd <= '{o, d, a, 1'b1};
		@(posedge clk_i);
		cv <= 1'b0;
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_i);
		while (rdy !== 1'b1) @(posedge clk_i);
	endtask
	task automatic t_reset;
		rd(3'h2, 32'h00FF, "stack top");
		rd(3'h4, 32'h68, "flag byte");
		settle;
		rd(3'h3, 32'h1234, "fetch counter");
		$display("reset test done");
	endtask
	task automatic t_regs;
		wb(1'b1, 3'h0, 32'hA5);
		rd(3'h0, 32'hA5, "sum register");
		chk("sum output", 32'hA5, {24'h0, sum});
		wb(1'b1, 3'h1, 32'hBEEF);
		rd(3'h1, 32'hBEEF, "pointer pair");
		chk("pointer output", 32'hBEEF, {16'h0, ptr});
		wb(1'b1, 3'h4, 32'h08);
		rd(3'h4, 32'h68, "flag fixed ones");
		wb(1'b1, 3'h6, 32'hFF);
		rd(3'h6, 32'h0, "unmapped");
		$display("register test done");
	endtask
	task automatic t_alu;
		op(OP_LDA, 8'h7F, 16'h0);
		op(OP_ADD, 8'h01, 16'h0);
		settle;
		rd(3'h0, 32'h80, "sum after add");
		rd(3'h4, 32'hFC, "flags signed wrap");
		op(OP_ADD, 8'h80, 16'h0);
		settle;
		rd(3'h4, 32'hEB, "flags carry zero");
		op(OP_SUB, 8'h01, 16'h0);
		settle;
		rd(3'h4, 32'h6D, "flags borrow");
		op(OP_BSGN, 8'h01, 16'h1111);
		rd(3'h3, 32'h1111, "signed branch");
		op(OP_BTST, 8'h08, 16'h0002);
		rd(3'h4, 32'h6C, "bit test carry");
		op(OP_BTST, 8'h08, 16'h0003);
		op(OP_JUMP, 8'h00, 16'h5678);
		op(OP_FETCH, 8'h00, 16'h0);
		settle;
		rd(3'h3, 32'h5679, "fetch after jump");
		chk("fetch output", 32'h5679, {16'h0, fch});
		$display("alu test done");
	endtask
	task automatic t_stack;
		slow <= 1'b1;
		wb(1'b1, 3'h2, 32'h0340);
		op(OP_RSP, 8'h00, 16'h0);
		settle;
		rd(3'h2, 32'h03FF, "stack low reload");
		op(OP_PSHA, 8'h00, 16'h0);
		settle;
		rd(3'h2, 32'h03FE, "stack after push");
		chk("pushed byte", 32'hFF, {24'h0, u_mem.store[16'h03FF]});
		op(OP_PULA, 8'h00, 16'h0);
		settle;
		rd(3'h2, 32'h03FF, "stack after pull");
		op(OP_PUSH_UPPER_BYTE, 8'h00, 16'h0);
		wb(1'b1, 3'h1, 32'h0011);
		op(OP_PULL_UPPER_BYTE, 8'h00, 16'h0);
		settle;
		rd(3'h1, 32'hBE11, "upper byte restored");
		op(OP_EA_SP, 8'h00, 16'h0010);
		settle;
		chk("stack offset address", 32'h040F, {16'h0, ea});
		op(OP_EA_HX, 8'h00, 16'h0001);
		settle;
		chk("indexed address", 32'hBE12, {16'h0, ea});
		$display("stack test done");
	endtask
	task automatic t_irq;
		irq <= 8'h05;
		op(OP_CLI, 8'h00, 16'h0);
		settle;
		rd(3'h3, 32'h2000, "highest request vector");
		rd(3'h4, 32'h6D, "mask on entry");
		rd(3'h2, 32'h03FA, "frame without upper byte");
		irq <= 8'h00;
		op(OP_RTI, 8'h00, 16'h0);
		settle;
		rd(3'h4, 32'h65, "mask restored");
		rd(3'h2, 32'h03FF, "stack after return");
		slow <= 1'b0;
		$display("interrupt test done");
	endtask
	task automatic t_wait;
		op(OP_WAIT, 8'h00, 16'h0);
		repeat (4) @(posedge clk_i);
		chk("clock in wait", 32'h0, {31'h0, clk_en});
		irq <= 8'h02;
		settle;
		chk("clock after wake", 32'h1, {31'h0, clk_en});
		rd(3'h3, 32'h2100, "second request vector");
		irq <= 8'h00;
		op(OP_RTI, 8'h00, 16'h0);
		settle;
		rd(3'h4, 32'h65, "mask clear after wait");
		$display("wait test done");
	endtask
	task automatic t_stop;
		int n;
		int rec;
		for (int k = 0; k < 2; k++)
		begin
			rec = (k == 0) ? 32 : 4096;
			srec <= (k == 0);
			op(OP_STOP, 8'h00, 16'h0);
			repeat (4) @(posedge clk_i);
			chk("clock in stop", 32'h0, {31'h0, clk_en});
			wake <= 1'b1;
			n = 0;
			do
			begin
				@(posedge clk_i);
				n++;
			end
			while (clk_en !== 1'b1);
			wake <= 1'b0;
			chk("recovery in range", 32'h1, {31'h0, n >= rec && n <= rec + 8});
			settle;
			rd(3'h4, 32'h65, "mask clear after stop");
		end
		// leave a wait by reset: the mask must come back set
		op(OP_WAIT, 8'h00, 16'h0);
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(3'h4, 32'h68, "mask after reset exit");
		rd(3'h2, 32'h00FF, "stack top after reset");
		settle;
		$display("stop test done");
	endtask
	task automatic t_brk;
		int n;
		for (int m = 0; m < 2; m++)
		begin
			mon <= (m == 1);
			brk <= 1'b1;
			op(OP_NOP, 8'h00, 16'h0);
			n = 0;
			while (force_ir !== 1'b1 && n < 50)
			begin
				@(posedge clk_i);
				n++;
			end
			chk("trap forced", 32'h1, {31'h0, force_ir});
			chk("trap opcode", 32'h5C, {24'h0, ir});
			settle;
			rd(3'h3, (m == 1) ? 32'h4000 : 32'h3000, "break vector");
			chk("break active", 32'h1, {31'h0, brk_act});
			brk <= 1'b0;
			op(OP_RTI, 8'h00, 16'h0);
			settle;
			chk("break ended", 32'h0, {31'h0, brk_act});
		end
		$display("break test done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_regs;
		t_alu;
		t_stack;
		t_irq;
		t_wait;
		t_stop;
		t_brk;
		complete_run;
	end
endmodule // cpm_regs_bench
